// file: core/fcs_pkg.sv
// Constants, types and register map of the flash capacitor charge sequencer
package fcs_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam longint CLK_HZ = 100_000_000;
  localparam longint TIMEOUT_MS = 20000;
  localparam longint TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int OFF_TIME_NS = 500;
  localparam int OFF_CYC = (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_TIME_US = 100;
  localparam int PROG_CYC = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int EOC_HITS = 8;

  // APB register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_TRIM_KEY = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_TRIM_CODE = 8'h14;

  // Control: minimum switch-off time in cycles
  localparam int OFF_W = 8;
  localparam logic [OFF_W-1:0] CTRL_RST = OFF_W'(OFF_CYC);

  // Interrupt status and mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TIMEOUT = 1;
  localparam int IRQ_PROG = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // Trim code register fields
  localparam int CODE_W = 8;
  localparam int TRIM_GO_BIT = 8;
  localparam int TRIM_FUSE_BIT = 9;

  // Unlock keys, values arbitrary
  localparam logic [31:0] KEY_A = 32'h0000_5a5a;
  localparam logic [31:0] KEY_B = 32'h0000_a5a5;

  // Status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_HITS_LSB = 4;
  localparam int ST_PUMP_BIT = 8;
  localparam int ST_GATE_BIT = 9;
  localparam int ST_UNLOCK_BIT = 10;
  localparam int ST_FUSE_BIT = 11;
  localparam int ST_BUSY_BIT = 12;
  localparam int ST_FILL_BIT = 13;

  typedef enum logic [1:0] {
    FCS_IDLE = 2'b00,
    FCS_ON = 2'b01,
    FCS_OFF = 2'b10,
    FCS_DONE = 2'b11
  } fcs_state_t;

  typedef struct packed {
    logic fill_req;
    logic cur_limit;
    logic eoc_hit;
    logic pump_good;
    logic lock_blown;
  } fcs_pins_t;

  localparam int PIN_W = $bits(fcs_pins_t);

endpackage

// file: core/fcs_sync.sv
// Two-stage synchroniser for the asynchronous pin inputs
`timescale 1ns/10ps
module fcs_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge mclk) begin
    if (srst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// file: core/fcs_top.sv
// Flash capacitor charge sequencer: switch cycling, completion, pump timer, trim access
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps

// Summary of operation
// - A high level on the fill request starts the switching cycles.
// - Each cycle turns the switch on until the current limit trips, then turns it off.
// - The end-of-charge comparator is looked at only while the switch is off.
// - Fill complete goes low only after end of charge was seen in eight cycles.
// - Dropping the fill request releases fill complete high and ends the operation.
// - Trim programming is refused until the unlock key sequence has been written.
// - Once the lock fuse is blown the unlock sequence is ignored for good.
// - The gate driver is enabled only while the pump runs and its output is good.
// - A rising fill request restarts the pump timer, which stops on reset and expiry.
module fcs_top #(
  parameter int EOC_COUNT = fcs_pkg::EOC_HITS,
  parameter logic [31:0] TIMEOUT_CYCLES = 32'(fcs_pkg::TIMEOUT_CYC),
  parameter logic [15:0] PROG_CYCLES = 16'(fcs_pkg::PROG_CYC)
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fcs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fill_req_pin,
  input wire logic cur_limit_pin,
  input wire logic eoc_cmp_pin,
  input wire logic pump_good_pin,
  input wire logic lock_fuse_pin,
  output logic switch_on,
  output logic fill_done_n,
  output logic pump_en,
  output logic gate_drive_en,
  output logic otp_prog,
  output logic [fcs_pkg::CODE_W-1:0] otp_code,
  output logic otp_burn_lock,
  output logic irq
);

  if (EOC_COUNT < 1 || EOC_COUNT > 15) begin : g_bad_count
    $error("EOC_COUNT must lie in 1..15");
  end
  if (TIMEOUT_CYCLES < 32'h0000_0002 || PROG_CYCLES < 16'h0002) begin : g_bad_time
    $error("TIMEOUT_CYCLES and PROG_CYCLES must be at least 2");
  end

  localparam logic [3:0] HIT_LAST = 4'(EOC_COUNT - 1);

  function automatic logic fcs_mapped(input logic [fcs_pkg::ADDR_W-1:0] a);
    fcs_mapped = (a == fcs_pkg::ADDR_CTRL) || (a == fcs_pkg::ADDR_STATUS) ||
                 (a == fcs_pkg::ADDR_IRQ_STAT) || (a == fcs_pkg::ADDR_IRQ_MASK) ||
                 (a == fcs_pkg::ADDR_TRIM_KEY) || (a == fcs_pkg::ADDR_TRIM_CODE);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  fcs_pkg::fcs_pins_t pins_raw;
  fcs_pkg::fcs_pins_t pins;

  assign pins_raw = '{fill_req: fill_req_pin, cur_limit: cur_limit_pin,
                      eoc_hit: eoc_cmp_pin, pump_good: pump_good_pin,
                      lock_blown: lock_fuse_pin};

  fcs_sync #(
    .W(fcs_pkg::PIN_W)
  ) u_sync (
    .mclk(mclk),
    .srst(srst),
    .d(pins_raw),
    .q(pins)
  );

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait state, yet every answer comes from a flop

  logic setup_ph;
  logic wr_acc;
  logic [31:0] rd_val;
  logic [fcs_pkg::OFF_W-1:0] off_time;
  logic [fcs_pkg::IRQ_W-1:0] irq_stat;
  logic [fcs_pkg::IRQ_W-1:0] irq_mask;
  logic [fcs_pkg::IRQ_W-1:0] next_irq_stat;
  logic [fcs_pkg::IRQ_W-1:0] irq_set;
  logic [31:0] status_word;
  fcs_pkg::fcs_state_t state;
  fcs_pkg::fcs_state_t next_state;
  logic [3:0] hits;
  logic timer_run;
  logic unlocked;
  logic prog_busy;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[fcs_pkg::ST_STATE_LSB +: 2] = state;
    status_word[fcs_pkg::ST_HITS_LSB +: 4] = hits;
    status_word[fcs_pkg::ST_PUMP_BIT] = timer_run;
    status_word[fcs_pkg::ST_GATE_BIT] = gate_drive_en;
    status_word[fcs_pkg::ST_UNLOCK_BIT] = unlocked;
    status_word[fcs_pkg::ST_FUSE_BIT] = pins.lock_blown;
    status_word[fcs_pkg::ST_BUSY_BIT] = prog_busy;
    status_word[fcs_pkg::ST_FILL_BIT] = pins.fill_req;
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      fcs_pkg::ADDR_CTRL: rd_val[fcs_pkg::OFF_W-1:0] = off_time;
      fcs_pkg::ADDR_STATUS: rd_val = status_word;
      fcs_pkg::ADDR_IRQ_STAT: rd_val[fcs_pkg::IRQ_W-1:0] = irq_stat;
      fcs_pkg::ADDR_IRQ_MASK: rd_val[fcs_pkg::IRQ_W-1:0] = irq_mask;
      fcs_pkg::ADDR_TRIM_CODE: rd_val[fcs_pkg::CODE_W-1:0] = otp_code;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !fcs_mapped(paddr);
      prdata <= (setup_ph && !pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      off_time <= fcs_pkg::CTRL_RST;
      irq_mask <= fcs_pkg::IRQ_RST;
    end else if (wr_acc) begin
      if (paddr == fcs_pkg::ADDR_CTRL) begin
        off_time <= pwdata[fcs_pkg::OFF_W-1:0];
      end
      if (paddr == fcs_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= pwdata[fcs_pkg::IRQ_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Switch cycle sequencer

  logic [fcs_pkg::OFF_W-1:0] off_cnt;
  logic eoc_seen;
  logic off_end;
  logic hit_now;

  // Off phase lasts at least one cycle even when the control field is zero
  assign off_end = ({1'b0, off_cnt} + 9'h001) >= {1'b0, off_time};
  assign hit_now = eoc_seen || pins.eoc_hit;

  always_comb begin
    next_state = state;
    unique case (state)
      fcs_pkg::FCS_IDLE: begin
        if (pins.fill_req) begin
          next_state = fcs_pkg::FCS_ON;
        end
      end
      fcs_pkg::FCS_ON: begin
        if (!pins.fill_req) begin
          next_state = fcs_pkg::FCS_IDLE;
        end else if (pins.cur_limit) begin
          next_state = fcs_pkg::FCS_OFF;
        end
      end
      fcs_pkg::FCS_OFF: begin
        if (!pins.fill_req) begin
          next_state = fcs_pkg::FCS_IDLE;
        end else if (off_end) begin
          next_state = (hit_now && hits == HIT_LAST) ? fcs_pkg::FCS_DONE : fcs_pkg::FCS_ON;
        end
      end
      fcs_pkg::FCS_DONE: begin
        if (!pins.fill_req) begin
          next_state = fcs_pkg::FCS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= fcs_pkg::FCS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Limit is seen two cycles late through the synchroniser; peak current overshoots a little
  always_ff @(posedge mclk) begin
    if (srst) begin
      switch_on <= 1'b0;
      fill_done_n <= 1'b1;
    end else begin
      switch_on <= (next_state == fcs_pkg::FCS_ON);
      fill_done_n <= (next_state != fcs_pkg::FCS_DONE);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      off_cnt <= '0;
      eoc_seen <= 1'b0;
    end else if (state == fcs_pkg::FCS_OFF) begin
      off_cnt <= off_cnt + 8'h01;
      if (pins.eoc_hit) begin
        eoc_seen <= 1'b1;
      end
    end else begin
      off_cnt <= '0;
      eoc_seen <= 1'b0;
    end
  end

  // Detections count over the whole operation, not only consecutive cycles
  always_ff @(posedge mclk) begin
    if (srst) begin
      hits <= 4'h0;
    end else if (state == fcs_pkg::FCS_IDLE) begin
      hits <= 4'h0;
    end else if (state == fcs_pkg::FCS_OFF && off_end && hit_now && hits != HIT_LAST) begin
      hits <= hits + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Charge pump timeout and gate driver enable

  logic fill_prev;
  logic fill_rise;
  logic [31:0] timer_cnt;
  logic timer_expire;

  assign fill_rise = pins.fill_req && !fill_prev;
  assign timer_expire = timer_run && !fill_rise && (timer_cnt == TIMEOUT_CYCLES - 32'h0000_0001);

  always_ff @(posedge mclk) begin
    if (srst) begin
      fill_prev <= 1'b0;
    end else begin
      fill_prev <= pins.fill_req;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      timer_run <= 1'b0;
      timer_cnt <= 32'h0000_0000;
    end else if (fill_rise) begin
      timer_run <= 1'b1;
      timer_cnt <= 32'h0000_0000;
    end else if (timer_expire) begin
      timer_run <= 1'b0;
    end else if (timer_run) begin
      timer_cnt <= timer_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pump_en <= 1'b0;
      gate_drive_en <= 1'b0;
    end else begin
      pump_en <= timer_run;
      // Needs the pump on for a cycle already, so a stale good level after a restart is ignored
      gate_drive_en <= pump_en && timer_run && pins.pump_good;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trim access: key sequence, code programming, lock fuse

  logic key_stage;
  logic key_wr;
  logic code_wr;
  logic [15:0] prog_cnt;
  logic prog_end;

  assign key_wr = wr_acc && paddr == fcs_pkg::ADDR_TRIM_KEY;
  assign code_wr = wr_acc && paddr == fcs_pkg::ADDR_TRIM_CODE && unlocked && !prog_busy;
  assign prog_end = prog_busy && prog_cnt == PROG_CYCLES - 16'h0001;

  // Wrong key anywhere in the sequence relocks, so a stray write cannot leave it open
  always_ff @(posedge mclk) begin
    if (srst) begin
      key_stage <= 1'b0;
      unlocked <= 1'b0;
    end else if (pins.lock_blown) begin
      key_stage <= 1'b0;
      unlocked <= 1'b0;
    end else if (key_wr) begin
      key_stage <= (pwdata == fcs_pkg::KEY_A);
      unlocked <= key_stage && (pwdata == fcs_pkg::KEY_B);
    end else if (prog_end && otp_burn_lock) begin
      unlocked <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      otp_code <= '0;
      otp_prog <= 1'b0;
      otp_burn_lock <= 1'b0;
      prog_busy <= 1'b0;
      prog_cnt <= 16'h0000;
    end else if (code_wr) begin
      otp_code <= pwdata[fcs_pkg::CODE_W-1:0];
      otp_prog <= pwdata[fcs_pkg::TRIM_GO_BIT];
      otp_burn_lock <= pwdata[fcs_pkg::TRIM_FUSE_BIT];
      prog_busy <= pwdata[fcs_pkg::TRIM_GO_BIT] || pwdata[fcs_pkg::TRIM_FUSE_BIT];
      prog_cnt <= 16'h0000;
    end else if (prog_end) begin
      otp_prog <= 1'b0;
      otp_burn_lock <= 1'b0;
      prog_busy <= 1'b0;
    end else if (prog_busy) begin
      prog_cnt <= prog_cnt + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, write one to clear, set wins

  logic [fcs_pkg::IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[fcs_pkg::IRQ_DONE] = (next_state == fcs_pkg::FCS_DONE) && (state != fcs_pkg::FCS_DONE);
    irq_set[fcs_pkg::IRQ_TIMEOUT] = timer_expire;
    irq_set[fcs_pkg::IRQ_PROG] = prog_end;
    irq_clr = (wr_acc && paddr == fcs_pkg::ADDR_IRQ_STAT) ? pwdata[fcs_pkg::IRQ_W-1:0] : '0;
    next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_stat <= fcs_pkg::IRQ_RST;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_mask);
    end
  end

endmodule

// file: sim/fcs_power_model.sv
// Power stage model: primary current limit, end-of-charge comparator, pump level
`timescale 1ns/10ps
module fcs_power_model (
  input wire logic mclk,
  input wire logic switch_on,
  input wire logic pump_en,
  input wire logic charged,
  input wire logic eoc_in_on,
  output logic cur_limit_pin,
  output logic eoc_cmp_pin,
  output logic pump_good_pin
);
  logic [3:0] on_cnt = 4'h0;
  logic [2:0] pump_cnt = 3'h0;
  always_ff @(posedge mclk) begin
    on_cnt <= switch_on ? on_cnt + 4'h1 : 4'h0;
  end
  always_ff @(posedge mclk) begin
    pump_cnt <= !pump_en ? 3'h0 : (pump_cnt == 3'h4 ? pump_cnt : pump_cnt + 3'h1);
  end
  // Current ramps only while the switch grounds the primary
  assign cur_limit_pin = on_cnt >= 4'h6;
  // Faulty mode shows the level during the on phase, cleared before the switch opens
  assign eoc_cmp_pin = charged & (eoc_in_on ? switch_on & !cur_limit_pin : !switch_on);
  assign pump_good_pin = pump_cnt == 3'h4;
endmodule

// file: sim/fcs_top_asserts.sv
// Assertions on the charge sequencer ports
`timescale 1ns/10ps
module fcs_top_asserts #(
  parameter logic [31:0] TIMEOUT_CYCLES = 32'h0000_00c8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic fill_req_pin,
  input wire logic cur_limit_pin,
  input wire logic eoc_cmp_pin,
  input wire logic pump_good_pin,
  input wire logic lock_fuse_pin,
  input wire logic switch_on,
  input wire logic fill_done_n,
  input wire logic pump_en,
  input wire logic gate_drive_en,
  input wire logic otp_prog
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  logic sw_q;
  logic req_q;
  logic eoc_ph;
  logic [3:0] eoc_offs;
  logic [31:0] pump_cnt;
  always_ff @(posedge mclk) begin
    sw_q <= switch_on;
    req_q <= fill_req_pin;
  end
  // Off phases in which the comparator was seen high with the switch open
  always_ff @(posedge mclk) begin
    if (srst || !fill_req_pin) begin
      eoc_ph <= 1'b0;
      eoc_offs <= 4'h0;
    end else if (!sw_q && switch_on) begin
      eoc_ph <= 1'b0;
      if (eoc_ph && eoc_offs != 4'hf) eoc_offs <= eoc_offs + 4'h1;
    end else if (!switch_on && eoc_cmp_pin) begin
      eoc_ph <= 1'b1;
    end
  end
  // Pin edge restarts early; the synchroniser lag is covered by the margin below
  always_ff @(posedge mclk) begin
    if (srst || !pump_en || (fill_req_pin && !req_q)) pump_cnt <= 32'h0;
    else pump_cnt <= pump_cnt + 32'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_req_rise;
    $rose(fill_req_pin) ##1 fill_req_pin [*3];
  endsequence
  sequence s_limit_hit;
    switch_on && cur_limit_pin;
  endsequence
  a_switch_start: assert property (s_req_rise |-> ##[0:2] switch_on)
    else $error("switching did not start");
  a_limit_off: assert property (s_limit_hit |-> ##[1:5] !switch_on)
    else $error("switch stayed on past current limit");
  a_done_count: assert property ($fell(fill_done_n) |-> eoc_offs >= 4'h7 && eoc_ph)
    else $error("completion before eight off phases");
  a_done_release: assert property ($fell(fill_req_pin) |-> ##[1:6] fill_done_n)
    else $error("completion not released");
  a_done_no_switch: assert property (!fill_done_n |-> !switch_on)
    else $error("switching while complete");
  a_gate_pump: assert property (gate_drive_en |-> $past(pump_en) && $past(pump_good_pin, 3))
    else $error("gate driver enabled without good pump");
  a_pump_start: assert property ($rose(fill_req_pin) |-> ##[1:6] pump_en)
    else $error("pump timer not started");
  a_pump_expire: assert property (pump_cnt <= TIMEOUT_CYCLES + 32'h4)
    else $error("pump ran past timeout");
  a_fuse_locks: assert property ($rose(otp_prog) |-> !$past(lock_fuse_pin, 3))
    else $error("programming after lock fuse");
endmodule
bind fcs_top fcs_top_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_asserts (.mclk(mclk),
  .srst(srst), .fill_req_pin(fill_req_pin), .cur_limit_pin(cur_limit_pin),
  .eoc_cmp_pin(eoc_cmp_pin),
  .pump_good_pin(pump_good_pin), .lock_fuse_pin(lock_fuse_pin), .switch_on(switch_on),
  .fill_done_n(fill_done_n), .pump_en(pump_en), .gate_drive_en(gate_drive_en),
  .otp_prog(otp_prog));

// file: sim/fcs_top_tb.sv
// Self-checking bench for the charge sequencer
`timescale 1ns/10ps
module fcs_top_tb;
  localparam logic [31:0] TMO = 32'h0000_0190;
  logic mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, fill_req_pin = 1'b0, lock_fuse_pin = 1'b0;
  logic charged = 1'b0, eoc_in_on = 1'b0, cur_limit_pin, eoc_cmp_pin, pump_good_pin;
  logic switch_on, fill_done_n, pump_en, gate_drive_en, otp_prog, otp_burn_lock, irq, prev, hi;
  logic [7:0] otp_code;
  int err_total = 0, tests_run = 0, n;
  always #5 mclk = ~mclk;
  fcs_top #(.EOC_COUNT(8), .TIMEOUT_CYCLES(TMO), .PROG_CYCLES(16'h0014)) dut (
    .mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .fill_req_pin, .cur_limit_pin, .eoc_cmp_pin, .pump_good_pin, .lock_fuse_pin, .switch_on,
    .fill_done_n, .pump_en, .gate_drive_en, .otp_prog, .otp_code, .otp_burn_lock, .irq);
  fcs_power_model model (.mclk, .switch_on, .pump_en, .charged, .eoc_in_on, .cur_limit_pin,
    .eoc_cmp_pin, .pump_good_pin);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Release costs an idle edge so no strobe is driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // No local limit: only the watchdog ends a hung access
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic unlock;
    apb(1'b1, fcs_pkg::ADDR_TRIM_KEY, fcs_pkg::KEY_A);
    apb(1'b1, fcs_pkg::ADDR_TRIM_KEY, fcs_pkg::KEY_B);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(1'b0, fcs_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'(fcs_pkg::CTRL_RST));
    apb(1'b0, fcs_pkg::ADDR_IRQ_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h18, 32'h1);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, fcs_pkg::ADDR_CTRL, 32'h4);
    apb(1'b0, fcs_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h4);
  endtask
  task automatic t_eoc_on;
    eoc_in_on <= 1'b1;
    charged <= 1'b1;
    fill_req_pin <= 1'b1;
    cyc(300);
    chk(32'(fill_done_n), 32'h1);
    fill_req_pin <= 1'b0;
    charged <= 1'b0;
    eoc_in_on <= 1'b0;
    cyc(6);
  endtask
  task automatic t_charge;
    apb(1'b1, fcs_pkg::ADDR_IRQ_STAT, 32'h7);
    apb(1'b1, fcs_pkg::ADDR_IRQ_MASK, 32'h1);
    fill_req_pin <= 1'b1;
    cyc(6);
    chk(32'(switch_on), 32'h1);
    cyc(60);
    chk(32'(fill_done_n), 32'h1);
    chk(32'(gate_drive_en), 32'h1);
    charged <= 1'b1;
    n = 0;
    prev = switch_on;
    for (int k = 0; k < 1000 && fill_done_n !== 1'b0; k++) begin
      @(posedge mclk);
      if (prev && !switch_on) n++;
      prev = switch_on;
    end
    chk(32'(n >= 7 && n <= 8), 32'h1);
    chk(32'(irq), 32'h1);
    hi = 1'b0;
    repeat (30) begin
      @(posedge mclk);
      hi = hi | switch_on;
    end
    chk(32'(hi), 32'h0);
    apb(1'b0, fcs_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, fcs_pkg::ADDR_IRQ_STAT, 32'h1);
    cyc(2);
    chk(32'(irq), 32'h0);
  endtask
  task automatic t_trim;
    apb(1'b1, fcs_pkg::ADDR_TRIM_CODE, 32'h0000_013c);
    chk(32'(otp_prog), 32'h0);
    unlock();
    apb(1'b1, fcs_pkg::ADDR_TRIM_CODE, 32'h0000_013c);
    chk(32'({otp_prog, otp_code}), 32'h13c);
    cyc(25);
    apb(1'b0, fcs_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(rd & 32'h4, 32'h4);
    unlock();
    apb(1'b1, fcs_pkg::ADDR_TRIM_CODE, 32'h0000_0200);
    chk(32'(otp_burn_lock), 32'h1);
    lock_fuse_pin <= 1'b1;
    cyc(25);
    unlock();
    apb(1'b1, fcs_pkg::ADDR_TRIM_CODE, 32'h0000_013c);
    chk(32'(otp_prog), 32'h0);
  endtask
  task automatic t_release;
    fill_req_pin <= 1'b0;
    cyc(6);
    chk(32'(fill_done_n), 32'h1);
    fill_req_pin <= 1'b1;
    cyc(6);
    chk(32'(switch_on), 32'h1);
    fill_req_pin <= 1'b0;
    charged <= 1'b0;
    cyc(6);
  endtask
  task automatic t_timeout;
    apb(1'b1, fcs_pkg::ADDR_IRQ_STAT, 32'h7);
    fill_req_pin <= 1'b1;
    cyc(10);
    chk(32'(pump_en), 32'h1);
    n = 0;
    while (pump_en === 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    chk(32'(n > 380 && n < 400), 32'h1);
    cyc(2);
    chk(32'(gate_drive_en), 32'h0);
    apb(1'b0, fcs_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(rd & 32'h2, 32'h2);
    fill_req_pin <= 1'b0;
  endtask
  task automatic print_verdict;
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    cyc(3);
    t_regs();
    t_eoc_on();
    t_charge();
    t_trim();
    t_release();
    t_timeout();
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    print_verdict();
  end
endmodule
